// *** sars_pkg.sv ***
package sars_pkg;

  // ----------------------------------------------------------------------
  // Widths and depth
  // ----------------------------------------------------------------------
  localparam int ADDR_W      = 8;
  localparam int STACK_DEPTH = 4;

  typedef logic [ADDR_W-1:0] sars_byte_t;
  typedef sars_byte_t [STACK_DEPTH-1:0] sars_stack_t;

  // ----------------------------------------------------------------------
  // Register locations
  // ----------------------------------------------------------------------
  localparam sars_byte_t CTRL_A_ADDR      = 8'h0A;
  localparam sars_byte_t HIST_SECOND_ADDR = 8'h4E;
  localparam sars_byte_t HIST_OTHER_ADDR  = 8'h4F;

  // ----------------------------------------------------------------------
  // Stack entry indices and field positions
  // ----------------------------------------------------------------------
  localparam int IDX_CURRENT = 0;
  localparam int IDX_FIRST   = 1;
  localparam int IDX_SECOND  = 2;
  localparam int IDX_OTHER   = 3;
  localparam int BANK_BIT    = 4;

  // ----------------------------------------------------------------------
  // Reset and idle values
  // ----------------------------------------------------------------------
  localparam sars_byte_t CTRL_A_RESET = 8'h00;
  localparam sars_byte_t ENTRY_RESET  = 8'h00;
  localparam sars_byte_t READ_IDLE    = 8'h00;

endpackage

// *** sars_stack.sv ***
`timescale 1ns/1ps

module sars_stack (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Push request
  input  wire logic                 push,
  input  wire sars_pkg::sars_byte_t push_data,
  // Stored entries, newest at index zero
  output sars_pkg::sars_stack_t     entries
);

  // ----------------------------------------------------------------------
  // Shift register storage
  // ----------------------------------------------------------------------
  sars_pkg::sars_stack_t entry_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      entry_reg[sars_pkg::IDX_CURRENT] <= sars_pkg::ENTRY_RESET;
    end else if (push) begin
      entry_reg[sars_pkg::IDX_CURRENT] <= push_data;
    end
  end

  // Deeper entries move one place down on every push; the oldest is lost.
  for (genvar i = 1; i < sars_pkg::STACK_DEPTH; i++) begin : g_shift
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        entry_reg[i] <= sars_pkg::ENTRY_RESET;
      end else if (push) begin
        entry_reg[i] <= entry_reg[i-1];
      end
    end
  end

  assign entries = entry_reg;

endmodule

// *** sars_top.sv ***
// Overview of operation
// (RULE1) Capture address when address strobe falls.
// (RULE2) Every capture pushes the history stack down.
// (RULE3) Four entries deep; oldest entry dropped.
// (RULE4) Two entries readable at 4Eh and 4Fh.
// (RULE5) Host captures 0Ah and sets bank bit.
// (RULE6) After 4Eh capture, 4Eh shows lost address.
// (RULE7) Host sets bank bit before extended access.
// (RULE8) Reading the stack never alters it.
`timescale 1ns/1ps

module sars_top (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Multiplexed host bus controls
  input  wire logic       ALE,
  input  wire logic       CS_N,
  input  wire logic       RD_N,
  input  wire logic       WR_N,
  // Multiplexed address and data lines
  input  wire logic [7:0] AD_IN,
  output logic      [7:0] AD_OUT,
  output logic            AD_OE_N,
  // Bank state
  output logic            BANK_SELECT
);

  // ----------------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------------
  logic ale_reg;
  logic wr_n_reg;
  logic ale_fall;
  logic wr_rise;
  logic rd_active;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ale_reg  <= 1'h0;
      wr_n_reg <= 1'h1;
    end else begin
      ale_reg  <= ALE;
      wr_n_reg <= WR_N;
    end
  end

  assign ale_fall  = ale_reg & ~ALE;
  assign wr_rise   = ~wr_n_reg & WR_N & ~CS_N;
  assign rd_active = ~CS_N & ~RD_N;

  // ----------------------------------------------------------------------
  // Address history stack
  // ----------------------------------------------------------------------
  sars_pkg::sars_stack_t entries;
  sars_pkg::sars_byte_t  cur_addr;

  // A falling address strobe latches the lines and pushes the stack.
  sars_stack u_stack (
    .clk       (CLK),
    .rst       (RST),
    .push      (ale_fall),
    .push_data (AD_IN),
    .entries   (entries)
  ); // RULE1 RULE2 RULE3

  assign cur_addr = entries[sars_pkg::IDX_CURRENT];

  // ----------------------------------------------------------------------
  // Control register A and bank select
  // ----------------------------------------------------------------------
  sars_pkg::sars_byte_t ctrl_a_reg;

  // Data is taken at the end of the write pulse.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_a_reg <= sars_pkg::CTRL_A_RESET;
    end else if (wr_rise && cur_addr == sars_pkg::CTRL_A_ADDR) begin
      ctrl_a_reg <= AD_IN;
    end
  end

  assign BANK_SELECT = ctrl_a_reg[sars_pkg::BANK_BIT];

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  sars_pkg::sars_byte_t read_next;
  sars_pkg::sars_byte_t read_reg;
  logic                 oe_n_reg;

  // Stack entries appear only in the extended bank; reads never push.
  always_comb begin
    if (cur_addr == sars_pkg::CTRL_A_ADDR) begin
      read_next = ctrl_a_reg;
    end else if (BANK_SELECT && cur_addr == sars_pkg::HIST_SECOND_ADDR) begin
      read_next = entries[sars_pkg::IDX_SECOND]; // RULE4 RULE6
    end else if (BANK_SELECT && cur_addr == sars_pkg::HIST_OTHER_ADDR) begin
      read_next = entries[sars_pkg::IDX_OTHER]; // RULE4
    end else begin
      read_next = sars_pkg::READ_IDLE;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      read_reg <= sars_pkg::READ_IDLE;
      oe_n_reg <= 1'h1;
    end else begin
      read_reg <= rd_active ? read_next : sars_pkg::READ_IDLE;
      oe_n_reg <= ~rd_active;
    end
  end

  assign AD_OUT  = read_reg;
  assign AD_OE_N = oe_n_reg;

  // ----------------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------------
  logic [2:0] fill_cnt_reg;

  // Counts captures since reset and stops at the stack depth, so that the
  // depth check knows when the deepest entry first receives an address.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fill_cnt_reg <= 3'h0;
    end else if (ale_fall && fill_cnt_reg != 3'(sars_pkg::STACK_DEPTH)) begin
      fill_cnt_reg <= fill_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_addr_capture: assert property (@(posedge CLK) disable iff (RST) // RULE1
    ale_fall |=> entries[sars_pkg::IDX_CURRENT] == $past(AD_IN))
    else $error("Address not captured on strobe fall.");

  a_stack_push: assert property (@(posedge CLK) disable iff (RST) // RULE2
    ale_fall |=> entries[sars_pkg::IDX_FIRST] == $past(entries[sars_pkg::IDX_CURRENT])
      && entries[sars_pkg::IDX_SECOND] == $past(entries[sars_pkg::IDX_FIRST]))
    else $error("Stack did not shift on push.");

  a_stack_depth: assert property (@(posedge CLK) disable iff (RST) // RULE3
    ale_fall |=> entries[sars_pkg::IDX_OTHER] == $past(entries[sars_pkg::IDX_SECOND]))
    else $error("Oldest entry not at depth four.");

  a_depth_fill: assert property (@(posedge CLK) disable iff (RST) // RULE3
    fill_cnt_reg < 3'(sars_pkg::STACK_DEPTH)
      |-> entries[sars_pkg::IDX_OTHER] == sars_pkg::ENTRY_RESET)
    else $error("Deepest entry filled before four captures.");

  a_hist_read: assert property (@(posedge CLK) disable iff (RST) // RULE4
    rd_active && BANK_SELECT && cur_addr == sars_pkg::HIST_OTHER_ADDR
      |=> !AD_OE_N && AD_OUT == $past(entries[sars_pkg::IDX_OTHER]))
    else $error("Location 4Fh read wrong entry.");

  a_lost_recover: assert property (@(posedge CLK) disable iff (RST) // RULE6
    ale_fall && AD_IN == sars_pkg::HIST_SECOND_ADDR
      && entries[sars_pkg::IDX_CURRENT] == sars_pkg::CTRL_A_ADDR
      |=> entries[sars_pkg::IDX_FIRST] == sars_pkg::CTRL_A_ADDR
      && entries[sars_pkg::IDX_SECOND] == $past(entries[sars_pkg::IDX_FIRST]))
    else $error("Lost address not presented at 4Eh.");

  a_read_no_pop: assert property (@(posedge CLK) disable iff (RST) // RULE8
    !ale_fall |=> $stable(entries))
    else $error("Stack changed without a capture.");

  a_read_keeps: assert property (@(posedge CLK) disable iff (RST) // RULE8
    rd_active && !ale_fall |=> $stable(entries))
    else $error("Stack changed by a read.");

  // ----------------------------------------------------------------------
  // Read path checks
  // ----------------------------------------------------------------------
  a_second_read: assert property (@(posedge CLK) disable iff (RST) // RULE4 RULE6
    rd_active && BANK_SELECT && cur_addr == sars_pkg::HIST_SECOND_ADDR
      |=> !AD_OE_N && AD_OUT == $past(entries[sars_pkg::IDX_SECOND]))
    else $error("Location 4Eh read wrong entry.");

  a_bank_gate: assert property (@(posedge CLK) disable iff (RST) // RULE4
    rd_active && !BANK_SELECT
      && (cur_addr == sars_pkg::HIST_SECOND_ADDR || cur_addr == sars_pkg::HIST_OTHER_ADDR)
      |=> AD_OUT == sars_pkg::READ_IDLE)
    else $error("Stack visible outside the extended bank.");

  a_unmapped_read: assert property (@(posedge CLK) disable iff (RST) // RULE4
    rd_active && cur_addr != sars_pkg::CTRL_A_ADDR
      && cur_addr != sars_pkg::HIST_SECOND_ADDR && cur_addr != sars_pkg::HIST_OTHER_ADDR
      |=> AD_OUT == sars_pkg::READ_IDLE)
    else $error("Unmapped location returned data.");

  a_ctrl_read: assert property (@(posedge CLK) disable iff (RST) // RULE4
    rd_active && cur_addr == sars_pkg::CTRL_A_ADDR
      |=> AD_OUT == $past(ctrl_a_reg))
    else $error("Control register read wrong value.");

  a_oe_drive: assert property (@(posedge CLK) disable iff (RST) // RULE4
    rd_active |=> !AD_OE_N)
    else $error("Lines not driven during a read.");

  a_oe_release: assert property (@(posedge CLK) disable iff (RST) // RULE4
    !rd_active |=> AD_OE_N && AD_OUT == sars_pkg::READ_IDLE)
    else $error("Lines still driven after a read.");

  a_read_steady: assert property (@(posedge CLK) disable iff (RST) // RULE8
    rd_active && !ale_fall && !wr_rise ##1 rd_active |=> $stable(AD_OUT))
    else $error("Read data changed during one read.");

  // ----------------------------------------------------------------------
  // Control register checks
  // ----------------------------------------------------------------------
  a_ctrl_write: assert property (@(posedge CLK) disable iff (RST) // RULE4
    wr_rise && cur_addr == sars_pkg::CTRL_A_ADDR
      |=> BANK_SELECT == $past(AD_IN[sars_pkg::BANK_BIT]))
    else $error("Bank select not taken from write data.");

  a_ctrl_hold: assert property (@(posedge CLK) disable iff (RST) // RULE4
    !(wr_rise && cur_addr == sars_pkg::CTRL_A_ADDR) |=> $stable(ctrl_a_reg))
    else $error("Control register changed without a write.");

endmodule

// *** sars_host_model.sv ***
`timescale 1ns/1ps

module sars_host_model (
  // Clock
  input  wire logic       clk,
  // Bus controls
  output logic            ale,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  // Bus lines
  output logic      [7:0] ad_in,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe_n
);
  initial begin
    ale = 1'h0;
    cs_n = 1'h1;
    rd_n = 1'h1;
    wr_n = 1'h1;
    ad_in = 8'hA5;
  end

  // Released lines show the inverse so a stale address cannot be mistaken for a hold.
  task automatic latch(input logic [7:0] a);
    @(negedge clk);
    ale <= 1'h1;
    ad_in <= a;
    @(negedge clk);
    ale <= 1'h0;
    @(negedge clk);
    ad_in <= ~a;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    latch(a);
    @(negedge clk);
    cs_n <= 1'h0;
    wr_n <= 1'h0;
    ad_in <= d;
    @(negedge clk);
    wr_n <= 1'h1;
    @(negedge clk);
    cs_n <= 1'h1;
    ad_in <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, input int hold, output logic [7:0] d,
                    output logic [7:0] d2);
    int i;
    latch(a);
    @(negedge clk);
    cs_n <= 1'h0;
    rd_n <= 1'h0;
    @(negedge clk);
    for (i = 0; i < 4 && ad_oe_n !== 1'h0; i++) @(negedge clk);
    d = ad_out;
    repeat (hold) @(negedge clk);
    d2 = ad_out;
    rd_n <= 1'h1;
    cs_n <= 1'h1;
    repeat (2) @(negedge clk);
  endtask
endmodule

// *** sars_top_tb_top.sv ***
`timescale 1ns/1ps

module sars_top_tb_top;
  logic       clk;
  logic       rst;
  logic       ale, cs_n, rd_n, wr_n, oe_n, bank;
  logic [7:0] ad_in, ad_out, d, d2;
  int         fails, num_checks, cycles, i;

  sars_top dut_u (.CLK(clk), .RST(rst), .ALE(ale), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
    .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE_N(oe_n), .BANK_SELECT(bank));
  sars_host_model host_u (.clk(clk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(oe_n));

  always #50 clk = ~clk;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    chk("bank", 8'h00, {7'h00, bank});
    host_u.rd(8'h4E, 0, d, d2);
    chk("hist_bank0", 8'h00, d);
    $display("test reset done");
    host_u.wr(8'h0A, 8'h10);
    chk("bank", 8'h01, {7'h00, bank});
    host_u.rd(8'h0A, 0, d, d2);
    chk("ctrl_a", 8'h10, d);
    for (i = 0; i < 3; i++) begin
      host_u.latch(8'h5A + 8'(i));
      host_u.latch(8'h0A);
      host_u.rd(8'h4E, 3, d, d2);
      chk("hist_second", 8'h5A + 8'(i), d);
      chk("hist_held", 8'h5A + 8'(i), d2);
      chk("oe_released", 8'h01, {7'h00, oe_n});
      chk("data_released", 8'h00, ad_out);
    end
    host_u.rd(8'h4F, 0, d, d2);
    chk("hist_oldest", 8'h5C, d);
    $display("test stack done");
    host_u.rd(8'h20, 0, d, d2);
    chk("unmapped", 8'h00, d);
    host_u.wr(8'h4E, 8'hFF);
    host_u.rd(8'h4E, 0, d, d2);
    chk("hist_ro", 8'h20, d);
    @(negedge clk);
    rst = 1'h1;
    @(negedge clk);
    rst = 1'h0;
    chk("bank_reset", 8'h00, {7'h00, bank});
    host_u.wr(8'h0A, 8'h10);
    host_u.rd(8'h4F, 0, d, d2);
    chk("hist_reset", 8'h00, d);
    $display("test midrun reset done");
    host_u.wr(8'h0A, 8'h00);
    host_u.rd(8'h4E, 0, d, d2);
    chk("hist_bank0", 8'h00, d);
    $display("test access done");
    test_done();
  end
endmodule
